// *** pmo_pkg.sv ***
// Constants and register map of the counter overflow interrupt block
// What this block does
// [RULE1] Writing 1 to an enable set bit enables that counter's interrupt.
// [RULE2] Reading the enable set view returns 1 per enabled counter.
// [RULE3] Writing 0 to any bit of any set or clear view changes nothing.
// [RULE4] Bank x holds counters x*32 to x*32+31; bits at or above m read 0.
// [RULE5] Writing 1 to an overflow clear bit clears that flag; reads show it.
// [RULE6] Writing 1 to an overflow set bit sets that flag; reads show it.
// [RULE7] Clearing an overflow flag withdraws its interrupt request.
// [RULE8] Each enable and overflow view is a 32-bit read-write register.
// [RULE9] Eight peripheral and four component identity registers, read-only.
// [RULE10] The monitor part number differs from the debug block part number.
// [RULE11] The overflow interrupt request is a top-level output.
// [RULE12] Writing 1 to an enable clear bit disables that counter's interrupt.
// [RULE13] The request is high while any counter is flagged and enabled.
// [RULE14] Overflow set and clear views share one flag per counter.
package pmo_pkg;

   // Bus and bank geometry
   localparam int ADDR_W   = 12;
   localparam int DATA_W   = 32;
   localparam int BANK_W   = 32;
   localparam int NUM_CNT  = 40;
   localparam int NUM_BANK = (NUM_CNT + BANK_W - 1) / BANK_W;
   localparam int PAD_W    = NUM_BANK * BANK_W;

   // Register offsets; banks step by one word
   localparam logic [ADDR_W-1:0] OFS_EN_SET  = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_EN_CLR  = 12'h020;
   localparam logic [ADDR_W-1:0] OFS_OVS_CLR = 12'h040;
   localparam logic [ADDR_W-1:0] OFS_OVS_SET = 12'h060;
   localparam logic [ADDR_W-1:0] OFS_PID     = 12'hfd0;
   localparam logic [ADDR_W-1:0] OFS_CID     = 12'hff0;
   localparam int                WORD_STEP   = 4;
   localparam int                NUM_PID     = 8;
   localparam int                NUM_CID     = 4;

   // Reset values of the state bits
   localparam logic [NUM_CNT-1:0] EN_RST  = '0;
   localparam logic [NUM_CNT-1:0] OVS_RST = '0;

   // Part numbers; values are arbitrary
   localparam logic [11:0] MON_PART_NUM   = 12'h3c1;
   localparam logic [11:0] DEBUG_PART_NUM = 12'h3c2;

   // Identity bytes; values other than the part number are arbitrary
   localparam logic [7:0] PID_VAL [NUM_PID] = '{
      MON_PART_NUM[7:0], {4'h1, MON_PART_NUM[11:8]}, 8'h0b, 8'h00,
      8'h04, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] CID_VAL [NUM_CID] = '{
      8'h0d, 8'h90, 8'h05, 8'hb1};

endpackage

// *** pmo_overflow_irq.sv ***
// Overflow flags, interrupt enables and identity registers of the monitor
`timescale 1ns/1ps

module pmo_overflow_irq (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         resetn,
   // Register port
   input  wire logic [pmo_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [pmo_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                         reg_write,
   input  wire logic                         reg_read,
   output logic      [pmo_pkg::DATA_W-1:0]   reg_rdata,
   // Overflow pulses from the counters
   input  wire logic [pmo_pkg::NUM_CNT-1:0]  counter_overflow,
   // Interrupt request to the system
   output logic                              overflow_irq
);
   import pmo_pkg::*;

   localparam int HI_W = NUM_CNT - BANK_W;

   logic [NUM_CNT-1:0] irq_enable_reg;
   logic [NUM_CNT-1:0] irq_enable_next;
   logic [NUM_CNT-1:0] ovf_flag_reg;
   logic [NUM_CNT-1:0] ovf_flag_next;
   logic [DATA_W-1:0]  rdata_reg;
   logic [DATA_W-1:0]  rdata_next;
   logic [NUM_CNT-1:0] en_set_w;
   logic [NUM_CNT-1:0] en_clr_w;
   logic [NUM_CNT-1:0] ovs_set_w;
   logic [NUM_CNT-1:0] ovs_clr_w;
   logic [PAD_W-1:0]   en_pad;
   logic [PAD_W-1:0]   ovf_pad;

   // Per-counter write decode; only ones act, unimplemented bits dropped
   for (genvar i = 0; i < NUM_CNT; i++) begin : g_bit
      localparam int B = i / BANK_W;
      localparam int J = i % BANK_W;
      localparam logic [ADDR_W-1:0] STEP = ADDR_W'(B * WORD_STEP);
      assign en_set_w[i]  = reg_write && reg_wdata[J] &&
                            reg_addr == OFS_EN_SET + STEP; // RULE1 RULE3 RULE4
      assign en_clr_w[i]  = reg_write && reg_wdata[J] &&
                            reg_addr == OFS_EN_CLR + STEP; // RULE12 RULE3
      assign ovs_set_w[i] = reg_write && reg_wdata[J] &&
                            reg_addr == OFS_OVS_SET + STEP; // RULE6 RULE3
      assign ovs_clr_w[i] = reg_write && reg_wdata[J] &&
                            reg_addr == OFS_OVS_CLR + STEP; // RULE5 RULE3
   end

   // Next enable and flag state; a counter event beats a clear
   always_comb begin
      irq_enable_next = (irq_enable_reg | en_set_w) & ~en_clr_w; // RULE1 RULE12
      ovf_flag_next   = (ovf_flag_reg & ~ovs_clr_w)
                        | ovs_set_w | counter_overflow; // RULE5 RULE6 RULE14
   end

   // Banks padded with zeros above the implemented count
   assign en_pad  = PAD_W'(irq_enable_reg); // RULE4
   assign ovf_pad = PAD_W'(ovf_flag_reg); // RULE4

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_next = '0;
      if (reg_read) begin
         for (int b = 0; b < NUM_BANK; b++) begin
            if (reg_addr == OFS_EN_SET + ADDR_W'(b * WORD_STEP) ||
                reg_addr == OFS_EN_CLR + ADDR_W'(b * WORD_STEP)) begin
               rdata_next = en_pad[b*BANK_W +: BANK_W]; // RULE2 RULE8
            end
            if (reg_addr == OFS_OVS_SET + ADDR_W'(b * WORD_STEP) ||
                reg_addr == OFS_OVS_CLR + ADDR_W'(b * WORD_STEP)) begin
               rdata_next = ovf_pad[b*BANK_W +: BANK_W]; // RULE14 RULE8
            end
         end
         for (int k = 0; k < NUM_PID; k++) begin
            if (reg_addr == OFS_PID + ADDR_W'(k * WORD_STEP)) begin
               rdata_next = DATA_W'(PID_VAL[k]); // RULE9 RULE10
            end
         end
         for (int k = 0; k < NUM_CID; k++) begin
            if (reg_addr == OFS_CID + ADDR_W'(k * WORD_STEP)) begin
               rdata_next = DATA_W'(CID_VAL[k]); // RULE9
            end
         end
      end
   end

   // State registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_enable_reg <= EN_RST;
         ovf_flag_reg   <= OVS_RST;
         rdata_reg      <= '0;
      end else begin
         irq_enable_reg <= irq_enable_next;
         ovf_flag_reg   <= ovf_flag_next;
         rdata_reg      <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // Level request from any flagged and enabled counter
   assign overflow_irq = |(ovf_flag_reg & irq_enable_reg); // RULE11 RULE13 RULE7

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   property p_en_set;
      reg_write && reg_addr == OFS_EN_SET
      |=> (irq_enable_reg[BANK_W-1:0] & $past(reg_wdata))
          == $past(reg_wdata);
   endproperty
   a_en_set: assert property (p_en_set) // RULE1
      else $error("enable set write did not enable");

   property p_en_read;
      reg_read && reg_addr == OFS_EN_SET
      |=> reg_rdata == $past(irq_enable_reg[BANK_W-1:0]);
   endproperty
   a_en_read: assert property (p_en_read) // RULE2
      else $error("enable set view read wrong");

   property p_zero_keeps;
      reg_write && reg_addr == OFS_EN_CLR
      |=> (irq_enable_reg[BANK_W-1:0] & ~$past(reg_wdata))
          == ($past(irq_enable_reg[BANK_W-1:0]) & ~$past(reg_wdata));
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) // RULE3
      else $error("zero bit changed enable state");

   property p_raz_high;
      reg_read && reg_addr == OFS_OVS_SET + ADDR_W'(WORD_STEP)
      |=> reg_rdata[DATA_W-1:HI_W] == '0;
   endproperty
   a_raz_high: assert property (p_raz_high) // RULE4
      else $error("unimplemented bits not zero");

   property p_ovs_clr;
      reg_write && reg_addr == OFS_OVS_CLR && reg_wdata[0]
      && !counter_overflow[0] |=> !ovf_flag_reg[0];
   endproperty
   a_ovs_clr: assert property (p_ovs_clr) // RULE5
      else $error("overflow clear did not clear");

   property p_ovs_set;
      reg_write && reg_addr == OFS_OVS_SET && reg_wdata[0]
      |=> ovf_flag_reg[0] ##1 ovf_flag_reg[0] || $past(reg_write);
   endproperty
   a_ovs_set: assert property (p_ovs_set) // RULE6
      else $error("overflow set did not set");

   property p_withdraw;
      reg_write && reg_addr == OFS_OVS_CLR && (&reg_wdata)
      && counter_overflow == '0 && ovf_flag_reg[NUM_CNT-1:BANK_W] == '0
      |=> !overflow_irq;
   endproperty
   a_withdraw: assert property (p_withdraw) // RULE7
      else $error("request not withdrawn after clear");

   property p_event_irq;
      counter_overflow[3] && irq_enable_reg[3]
      && !(reg_write && reg_addr == OFS_EN_CLR)
      |=> overflow_irq && ovf_flag_reg[3];
   endproperty
   a_event_irq: assert property (p_event_irq) // RULE13 RULE11
      else $error("enabled overflow raised no request");

   property p_en_clr;
      reg_write && reg_addr == OFS_EN_CLR && reg_wdata[0]
      |=> !irq_enable_reg[0] && !(reg_read && $past(reg_read)
          && reg_rdata[0] && $past(reg_addr) == OFS_EN_SET);
   endproperty
   a_en_clr: assert property (p_en_clr) // RULE12
      else $error("enable clear did not disable");

   property p_shared;
      reg_read && (reg_addr == OFS_OVS_CLR || reg_addr == OFS_OVS_SET)
      |=> reg_rdata == $past(ovf_flag_reg[BANK_W-1:0]);
   endproperty
   a_shared: assert property (p_shared) // RULE14
      else $error("overflow views disagree");

   property p_id_ro;
      reg_read && reg_addr == OFS_PID
      |=> reg_rdata == DATA_W'(PID_VAL[0]);
   endproperty
   a_id_ro: assert property (p_id_ro) // RULE9
      else $error("identity register changed");

   property p_part_num;
      reg_read |-> {PID_VAL[1][3:0], PID_VAL[0]} != DEBUG_PART_NUM;
   endproperty
   a_part_num: assert property (p_part_num) // RULE10
      else $error("part number equals debug part number");

endmodule

// *** pmo_overflow_irq_tb.sv ***
// Self-checking bench for the counter overflow interrupt block
`timescale 1ns/1ps

module pmo_overflow_irq_tb;
   import pmo_pkg::*;

   // Design ports
   logic                clk = 1'b0;
   logic                resetn = 1'b0;
   logic [ADDR_W-1:0]   reg_addr = '0;
   logic [DATA_W-1:0]   reg_wdata = '0;
   logic                reg_write = 1'b0;
   logic                reg_read = 1'b0;
   logic [DATA_W-1:0]   reg_rdata;
   logic [NUM_CNT-1:0]  counter_overflow = '0;
   logic                overflow_irq;
   // Bench model and bookkeeping
   logic [NUM_CNT-1:0]  en_m = '0;
   logic [NUM_CNT-1:0]  ovf_m = '0;
   int                  num_errors = 0;
   int                  checks_done = 0;
   int                  cycles = 0;
   logic [ADDR_W-1:0]   views [8] = '{OFS_EN_SET, OFS_EN_SET + 12'h4,
      OFS_EN_CLR, OFS_EN_CLR + 12'h4, OFS_OVS_CLR, OFS_OVS_CLR + 12'h4,
      OFS_OVS_SET, OFS_OVS_SET + 12'h4};

   pmo_overflow_irq dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .counter_overflow(counter_overflow),
      .overflow_irq(overflow_irq));

   // Clock, 20 ns period
   initial begin
      forever #10 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Expected read value of any word-aligned address
   function automatic logic [31:0] exp_rd(logic [ADDR_W-1:0] a);
      logic [63:0] p;
      p = {{(64 - NUM_CNT){1'b0}}, (a[6] ? ovf_m : en_m)};
      if (a >= OFS_CID) return {24'h0, CID_VAL[(a - OFS_CID) >> 2]};
      if (a >= OFS_PID) return {24'h0, PID_VAL[(a - OFS_PID) >> 2]};
      if ((a & 12'hf9b) != 12'h000) return '0;
      return a[2] ? p[63:32] : p[31:0];
   endfunction

   task automatic chk_irq();
      #1 chk("irq", overflow_irq, |(en_m & ovf_m));
   endtask

   task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
      logic [63:0] m;
      m = {32'h0, d} << (a[2] ? 32 : 0);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      if ((a & 12'hf9b) == 12'h000) begin
         case (a[6:5])
            2'b00: en_m = en_m | m[NUM_CNT-1:0];
            2'b01: en_m = en_m & ~m[NUM_CNT-1:0];
            2'b10: ovf_m = ovf_m & ~m[NUM_CNT-1:0];
            default: ovf_m = ovf_m | m[NUM_CNT-1:0];
         endcase
      end
      chk_irq();
   endtask

   task automatic rd(logic [ADDR_W-1:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 chk("rdata", reg_rdata, exp_rd(a));
   endtask

   task automatic ev(logic [NUM_CNT-1:0] d);
      @(posedge clk);
      counter_overflow <= d;
      @(posedge clk);
      counter_overflow <= '0;
      ovf_m = ovf_m | d;
      chk_irq();
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      void'($urandom(86));
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      foreach (views[i]) rd(views[i]);
      chk_irq();
      $display("test reset done");
      repeat (300) begin
         case ($urandom_range(3))
            0: wr(views[$urandom_range(7)], $urandom());
            1: ev(NUM_CNT'(1) << $urandom_range(NUM_CNT - 1));
            default: rd(views[$urandom_range(7)]);
         endcase
      end
      $display("test random done");
      // Unmapped and identity places ignore writes
      wr(12'h100, 32'hffffffff);
      rd(12'h100);
      wr(OFS_PID, 32'hffffffff);
      for (int i = 0; i < NUM_PID; i++) rd(OFS_PID + ADDR_W'(4 * i));
      for (int i = 0; i < NUM_CID; i++) rd(OFS_CID + ADDR_W'(4 * i));
      chk("part", {PID_VAL[1][3:0], PID_VAL[0]} != DEBUG_PART_NUM[11:0], 1);
      $display("test ident done");
      // Event in the same cycle as a clear keeps the flag
      wr(OFS_EN_SET, 32'h1);
      @(posedge clk);
      counter_overflow <= NUM_CNT'(1);
      reg_addr <= OFS_OVS_CLR;
      reg_wdata <= 32'h1;
      reg_write <= 1'b1;
      @(posedge clk);
      counter_overflow <= '0;
      reg_write <= 1'b0;
      ovf_m[0] = 1'b1;
      chk_irq();
      rd(OFS_OVS_SET);
      // Clearing every flag withdraws the request
      wr(OFS_OVS_CLR, 32'hffffffff);
      wr(OFS_OVS_CLR + 12'h4, 32'hffffffff);
      rd(OFS_OVS_CLR + 12'h4);
      $display("test clear done");
      tally_and_finish();
   end
endmodule
